// *** hdl/ccs_pkg.sv ***
/*
  Shared constants for the camera configuration set manager: register
  map, field positions, reset values, set codes and factory images.
  Assumes a 32-bit register port with byte addresses in 8 bits.
*/
package ccs_pkg;

  // Parameter set geometry
  localparam int PARAM_W = 16;
  localparam int PARAM_N = 8;
  localparam int IDX_W   = 3;
  localparam int LUT_N   = 4;
  localparam int SLOT_N  = 3;

  // Register byte addresses
  localparam logic [7:0] ADDR_LIVE_BASE      = 8'h00; // 8 words
  localparam logic [7:0] ADDR_FACTORY_CHOICE = 8'h20;
  localparam logic [7:0] ADDR_SLOT_CHOICE    = 8'h24;
  localparam logic [7:0] ADDR_STORE_CMD      = 8'h28;
  localparam logic [7:0] ADDR_RESTORE_CMD    = 8'h2C;
  localparam logic [7:0] ADDR_BOOT_CHOICE    = 8'h30;
  localparam logic [7:0] ADDR_STATUS         = 8'h34;
  localparam logic [7:0] ADDR_LUT_BASE       = 8'h40; // 4 words

  // Status register bit positions
  localparam int ST_BUSY     = 0;
  localparam int ST_REFUSED  = 1;
  localparam int ST_ACQ      = 2;
  localparam int ST_VALID_LO = 4;

  // Factory image codes
  typedef enum logic [1:0] {
    IMG_STANDARD  = 2'h0,
    IMG_HIGH_GAIN = 2'h1,
    IMG_AUTO      = 2'h2,
    IMG_COLOUR    = 2'h3
  } ccs_image_t;

  // Set sources: default set or user slot 1..3
  localparam logic [1:0] SRC_DEFAULT = 2'h0;

  // Values after reset
  localparam ccs_image_t FACTORY_CHOICE_RST = IMG_AUTO;
  localparam logic [1:0] BOOT_CHOICE_RST    = SRC_DEFAULT;
  localparam logic [1:0] SLOT_CHOICE_RST    = 2'h1;
  localparam logic [PARAM_W-1:0] LIVE_RST   = 16'h0000;
  localparam logic [PARAM_W-1:0] LUT_RST    = 16'h0000;

  // Parameter word indices
  localparam logic [IDX_W-1:0] P_GAIN      = 3'h0;
  localparam logic [IDX_W-1:0] P_EXPOSURE  = 3'h1;
  localparam logic [IDX_W-1:0] P_GAIN_AUTO = 3'h2;
  localparam logic [IDX_W-1:0] P_EXPO_AUTO = 3'h3;
  localparam logic [IDX_W-1:0] P_AUTO_POL  = 3'h4;
  localparam logic [IDX_W-1:0] P_WB_RED    = 3'h6;
  localparam logic [IDX_W-1:0] P_WB_BLUE   = 3'h7;

  // Factory parameter values; gain scale is 6 dB per GAIN_6DB step
  localparam logic [PARAM_W-1:0] GAIN_LOW     = 16'h0000;
  localparam logic [PARAM_W-1:0] GAIN_6DB     = 16'h0040;
  localparam logic [PARAM_W-1:0] EXPOSURE_DEF = 16'h0BB8;
  localparam logic [PARAM_W-1:0] AUTO_OFF     = 16'h0000;
  localparam logic [PARAM_W-1:0] AUTO_CONT    = 16'h0002;
  localparam logic [PARAM_W-1:0] POL_MIN_GAIN = 16'h0001;
  localparam logic [PARAM_W-1:0] WB_UNITY     = 16'h0100;
  localparam logic [PARAM_W-1:0] WB_DAY_RED   = 16'h0180;
  localparam logic [PARAM_W-1:0] WB_DAY_BLUE  = 16'h0140;

  // Copy engine states
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_BOOT = 4'h2,
    ST_LOAD = 4'h4,
    ST_SAVE = 4'h8
  } ccs_state_t;

  // One word of a fixed factory image; images differ from standard only
  function automatic logic [PARAM_W-1:0] ccs_factory_word(
      input ccs_image_t img, input logic [IDX_W-1:0] idx);
    logic [PARAM_W-1:0] w;
    w = 16'h0000;
    if (idx == P_EXPOSURE) w = EXPOSURE_DEF;
    if (idx == P_WB_RED || idx == P_WB_BLUE) w = WB_UNITY;
    if (img == IMG_HIGH_GAIN && idx == P_GAIN) w = GAIN_6DB;
    if (img == IMG_AUTO && (idx == P_GAIN_AUTO || idx == P_EXPO_AUTO))
      w = AUTO_CONT;
    if (img == IMG_AUTO && idx == P_AUTO_POL) w = POL_MIN_GAIN;
    if (img == IMG_COLOUR && idx == P_WB_RED) w = WB_DAY_RED;
    if (img == IMG_COLOUR && idx == P_WB_BLUE) w = WB_DAY_BLUE;
    return w;
  endfunction

endpackage

// *** hdl/ccs_nv_store.sv ***
/*
  Non-volatile store: three user slots, the factory image choice and
  the boot source choice. Only nv_rst_n (factory initialisation)
  touches it; the system reset leaves it alone.
*/
`timescale 1ns/1ns
module ccs_nv_store
  import ccs_pkg::*;
(
  // Clock, factory initialisation, enable
  input  wire logic                 clk,
  input  wire logic                 nv_rst_n,
  input  wire logic                 ce,
  // Choice writes
  input  wire logic                 fc_we,
  input  wire ccs_image_t           fc_wdata,
  input  wire logic                 bc_we,
  input  wire logic [1:0]           bc_wdata,
  // Slot write port, slot is 1..3
  input  wire logic                 wr_en,
  input  wire logic [1:0]           wr_slot,
  input  wire logic [IDX_W-1:0]     wr_idx,
  input  wire logic [PARAM_W-1:0]   wr_data,
  input  wire logic                 wr_last,
  // Read port, source 0 is the default set
  input  wire logic [1:0]           rd_src,
  input  wire logic [IDX_W-1:0]     rd_idx,
  output logic      [PARAM_W-1:0]   rd_word,
  // Stored state
  output ccs_image_t                factory_choice,
  output logic      [1:0]           boot_choice,
  output logic      [SLOT_N-1:0]    slot_valid
);

  logic [PARAM_W-1:0] mem [SLOT_N][PARAM_N];
  ccs_image_t         fc_ff;
  logic [1:0]         bc_ff;
  logic [SLOT_N-1:0]  valid_ff;
  logic [1:0]         wr_row;
  logic [1:0]         rd_row;

  assign wr_row = wr_slot - 2'h1;
  assign rd_row = rd_src - 2'h1;

  // Choices persist across system reset; shipped as auto image
  always_ff @(posedge clk or negedge nv_rst_n) begin
    if (!nv_rst_n) begin
      fc_ff <= FACTORY_CHOICE_RST;                     // [RQ6] [RQ10]
      bc_ff <= BOOT_CHOICE_RST;
    end else if (ce) begin
      if (fc_we) fc_ff <= fc_wdata;                    // [RQ12]
      if (bc_we) bc_ff <= bc_wdata;                    // [RQ19]
    end
  end

  // Slot contents hold no reset; valid bits guard unsaved slots
  always_ff @(posedge clk) begin
    if (ce && wr_en) mem[wr_row][wr_idx] <= wr_data;    // [RQ7] [RQ13]
  end

  // A slot counts as saved once its last word is written
  always_ff @(posedge clk or negedge nv_rst_n) begin
    if (!nv_rst_n) valid_ff <= '0;
    else if (ce && wr_en && wr_last) valid_ff[wr_row] <= 1'b1;
  end

  // Factory images are constants: no write path reaches them
  assign rd_word = (rd_src == SRC_DEFAULT)
                 ? ccs_factory_word(fc_ff, rd_idx)     // [RQ3] [RQ4] [RQ5]
                 : mem[rd_row][rd_idx];
  assign factory_choice = fc_ff;
  assign boot_choice    = bc_ff;
  assign slot_valid     = valid_ff;

endmodule

// *** hdl/ccs_config_sets.sv ***
/*
  Configuration set manager: live parameter set, register port,
  copy engine for boot, load and save between live set and store.
  Assumes acq_busy comes from logic on clk, and nv_rst_n is asserted
  only at factory initialisation, never by the system reset.
  Live writes meeting a copy are lost.
*/
`timescale 1ns/1ns
// Functional notes
// [RQ1] Live set sits in flops cleared by every reset.
// [RQ2] Host parameter writes go straight to the live set, which drives.
// [RQ3] Four factory images are constants with no write path.
// [RQ4] Standard image: low gain, autos off; high gain adds six dB.
// [RQ5] Auto image: gain and exposure auto continuous, gain kept minimal.
// [RQ6] Factory image choice survives reset in the non-volatile store.
// [RQ7] Three non-volatile user slots each hold the live parameters.
// [RQ8] After reset the startup set is copied into the live set.
// [RQ9] The brightness table is never saved to a user slot.
// [RQ10] Shipped factory choice is the automatic-functions image.
// [RQ11] Host changes factory choice only while camera is idle.
// [RQ12] Factory choice takes standard, high gain, auto or colour.
// [RQ13] Saving a slot overwrites every word it held.
// [RQ14] Store command with slot 1 to 3 copies live set there.
// [RQ15] Host may load the default set into the live set.
// [RQ16] Host may load any saved user slot into the live set.
// [RQ17] Restore command copies selected slot or default into live set.
// [RQ18] Host loads sets only while the camera is not acquiring.
// [RQ19] Boot source choice picks slot 1 to 3 or default set.
// [RQ20] Choice change or load during acquisition is ignored. Boot choice writes are taken even during acquisition.
module ccs_config_sets
  import ccs_pkg::*;
(
  // Clock, reset, enable
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  input  wire logic                       ce,
  input  wire logic                       nv_rst_n,
  // Acquisition state from the sensor controller
  input  wire logic                       acq_busy,
  // Register port
  input  wire logic [7:0]                 reg_addr,
  input  wire logic [31:0]                reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  output logic      [31:0]                reg_rdata,
  // Live configuration to the camera datapath
  output logic      [PARAM_N*PARAM_W-1:0] live_params,
  output logic      [LUT_N*PARAM_W-1:0]   lut_table,
  output logic                            cfg_busy
);

  // Address decoders shared by the write and read paths
  function automatic logic is_live(input logic [7:0] a);
    return a[7:5] == ADDR_LIVE_BASE[7:5];
  endfunction

  function automatic logic is_lut(input logic [7:0] a);
    return a[7:4] == ADDR_LUT_BASE[7:4];
  endfunction

  // Default set always there; slots once saved
  function automatic logic src_ready(input logic [1:0]        src,
                                     input logic [SLOT_N-1:0] v);
    if (src == SRC_DEFAULT) return 1'b1;
    return v[src - 2'h1];
  endfunction

  // Copy engine
  ccs_state_t         state_ff;
  ccs_state_t         nxt_state;
  logic [IDX_W-1:0]   idx_ff;
  logic [1:0]         src_ff;
  logic [1:0]         slot_sel_ff;

  // Status and read data
  logic               refused_ff;
  logic               busy_ff;
  logic [31:0]        rdata_ff;
  logic [31:0]        nxt_rdata;

  // Volatile words
  logic [PARAM_W-1:0] live_ff [PARAM_N];
  logic [PARAM_W-1:0] lut_ff  [LUT_N];

  // Store side
  ccs_image_t         factory_choice;
  logic [1:0]         boot_choice;
  logic [SLOT_N-1:0]  slot_valid;
  logic [PARAM_W-1:0] rd_word;
  logic [1:0]         rd_src;
  logic [1:0]         boot_src;

  // Request decode
  logic idle;
  logic last_word;
  logic copy_in;

  // Raw strobes
  logic store_req;
  logic restore_req;
  logic fc_req;
  logic bc_req;

  // Guarded strobes
  logic store_ok;
  logic restore_ok;
  logic fc_ok;

  // Refusals
  logic refuse_evt;
  logic refused_clr;
  logic sel_valid;

  // Engine decodes
  assign idle      = (state_ff == ST_IDLE);
  assign last_word = (idx_ff == IDX_W'(PARAM_N - 1));
  assign copy_in   = (state_ff == ST_BOOT) || (state_ff == ST_LOAD);

  // Command strobes; a command takes effect on a written 1 in bit 0
  assign store_req   = reg_wr && (reg_addr == ADDR_STORE_CMD)
                       && reg_wdata[0];
  assign restore_req = reg_wr && (reg_addr == ADDR_RESTORE_CMD)
                       && reg_wdata[0];
  assign fc_req      = reg_wr && (reg_addr == ADDR_FACTORY_CHOICE);
  assign bc_req      = reg_wr && (reg_addr == ADDR_BOOT_CHOICE);

  // A user slot that was never saved cannot be loaded
  assign sel_valid = src_ready(slot_sel_ff, slot_valid);

  // Saving needs a user slot; the default set is read-only
  assign store_ok   = store_req && idle
                      && (slot_sel_ff != SRC_DEFAULT);   // [RQ3] [RQ14]
  // Loads and factory choice changes wait for an idle camera
  assign restore_ok = restore_req && idle && !acq_busy
                      && sel_valid;                     // [RQ18] [RQ20]
  assign fc_ok      = fc_req && idle && !acq_busy;      // [RQ11] [RQ20]

  // Refused requests change nothing but leave a sticky flag
  assign refuse_evt  = (store_req && !store_ok)
                     || (restore_req && !restore_ok)
                     || (fc_req && !fc_ok);
  assign refused_clr = reg_wr && (reg_addr == ADDR_STATUS)
                       && reg_wdata[ST_REFUSED];

  // Boot falls back to the default set if its slot was never saved
  assign boot_src = src_ready(boot_choice, slot_valid)
                  ? boot_choice : SRC_DEFAULT;
  // Boot reads the stored choice
  assign rd_src   = (state_ff == ST_BOOT) ? boot_src : src_ff;

  // Non-volatile store with fixed factory images
  // Save path sees live words only
  ccs_nv_store u_store (
    .clk            (clk),
    .nv_rst_n       (nv_rst_n),
    .ce             (ce),
    .fc_we          (fc_ok),
    .fc_wdata       (ccs_image_t'(reg_wdata[1:0])),
    .bc_we          (bc_req),
    .bc_wdata       (reg_wdata[1:0]),
    .wr_en          (state_ff == ST_SAVE),
    .wr_slot        (src_ff),
    .wr_idx         (idx_ff),
    .wr_data        (live_ff[idx_ff]),    // [RQ9]
    .wr_last        (last_word),
    .rd_src         (rd_src),
    .rd_idx         (idx_ff),
    .rd_word        (rd_word),
    .factory_choice (factory_choice),
    .boot_choice    (boot_choice),
    .slot_valid     (slot_valid)
  );

  // Copy engine: one word per cycle, boot runs first after reset
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (store_ok) begin
          nxt_state = ST_SAVE;                          // [RQ14]
        end else if (restore_ok) begin
          nxt_state = ST_LOAD;                          // [RQ15] [RQ16]
        end
      end
      // All three copies walk eight words
      ST_BOOT, ST_LOAD, ST_SAVE: begin
        if (last_word) begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // Every reset reloads the live set
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ST_BOOT;                              // [RQ8]
    end else if (ce) begin
      state_ff <= nxt_state;
    end
  end

  // Word counter restarts at zero for every copy
  // Idle holds it at zero for a clean start
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idx_ff <= '0;
    end else if (ce) begin
      if (idle || last_word) begin
        idx_ff <= '0;
      end else begin
        idx_ff <= idx_ff + 3'h1;
      end
    end
  end

  // Source slot is latched so a later selector write cannot split a copy
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      src_ff <= SRC_DEFAULT;
    end else if (ce && idle && (store_ok || restore_ok)) begin
      src_ff <= slot_sel_ff;                            // [RQ17]
    end
  end

  // Slot selector: 0 selects the default set, 1..3 the user slots
  // A copy in flight uses its latch
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      slot_sel_ff <= SLOT_CHOICE_RST;
    end else if (ce && reg_wr && reg_addr == ADDR_SLOT_CHOICE) begin
      slot_sel_ff <= reg_wdata[1:0];                    // [RQ14] [RQ17]
    end
  end

  // Live set: volatile, filled by copies, else by host writes
  // Host writes during a copy are lost
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < PARAM_N; i++) begin
        live_ff[i] <= LIVE_RST;                         // [RQ1]
      end
    end else if (ce) begin
      if (copy_in) begin
        live_ff[idx_ff] <= rd_word;                     // [RQ8] [RQ17]
      end else if (idle && reg_wr && is_live(reg_addr)) begin
        live_ff[reg_addr[4:2]] <= reg_wdata[PARAM_W-1:0]; // [RQ2]
      end
    end
  end

  // Brightness table: host-written, lost on reset, never saved
  // Software reloads it after reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < LUT_N; i++) begin
        lut_ff[i] <= LUT_RST;                           // [RQ9]
      end
    end else if (ce && reg_wr && is_lut(reg_addr)) begin
      lut_ff[reg_addr[3:2]] <= reg_wdata[PARAM_W-1:0];
    end
  end

  // Sticky refusal flag; a new refusal wins over a clear
  // Cleared by writing 1 to its bit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      refused_ff <= 1'b0;
    end else if (ce) begin
      if (refuse_evt) begin
        refused_ff <= 1'b1;                             // [RQ20]
      end else if (refused_clr) begin
        refused_ff <= 1'b0;
      end
    end
  end

  // Busy covers boot, load and save
  // From nxt_state, in step with state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_ff <= 1'b1;
    end else if (ce) begin
      busy_ff <= (nxt_state != ST_IDLE);
    end
  end

  // Read mux; unmapped addresses read as zero
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (is_live(reg_addr)) begin
      nxt_rdata[PARAM_W-1:0] = live_ff[reg_addr[4:2]];
    end else if (is_lut(reg_addr)) begin
      nxt_rdata[PARAM_W-1:0] = lut_ff[reg_addr[3:2]];
    end else begin
      case (reg_addr)
        ADDR_FACTORY_CHOICE: nxt_rdata[1:0] = factory_choice;
        ADDR_SLOT_CHOICE:    nxt_rdata[1:0] = slot_sel_ff;
        ADDR_BOOT_CHOICE:    nxt_rdata[1:0] = boot_choice;
        ADDR_STATUS: begin
          nxt_rdata[ST_BUSY]    = busy_ff;
          nxt_rdata[ST_REFUSED] = refused_ff;
          nxt_rdata[ST_ACQ]     = acq_busy;
          nxt_rdata[ST_VALID_LO +: SLOT_N] = slot_valid;
        end
        // Commands read back as zero
        default: nxt_rdata = 32'h0000_0000;
      endcase
    end
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= 32'h0000_0000;
    end else if (ce) begin
      if (reg_rd) begin
        rdata_ff <= nxt_rdata;
      end else begin
        rdata_ff <= 32'h0000_0000;
      end
    end
  end

  // Flatten flop arrays onto the output buses
  for (genvar g = 0; g < PARAM_N; g++) begin : g_live
    assign live_params[g*PARAM_W +: PARAM_W] = live_ff[g];
  end

  for (genvar g = 0; g < LUT_N; g++) begin : g_lut
    assign lut_table[g*PARAM_W +: PARAM_W] = lut_ff[g];
  end

  // Ports straight from flops
  assign reg_rdata = rdata_ff;
  assign cfg_busy  = busy_ff;

endmodule

// *** verification/ccs_config_sets_properties.sv ***
/*
  Checker for the configuration set manager: timing of the copy engine,
  register port answers and refusals, seen only at the top ports.
  Assumes one clock, rst_n async active low, ce held high by the bench.
*/
`timescale 1ns/1ns
module ccs_config_sets_properties
  import ccs_pkg::*;
(
  // Clock, reset, enable, acquisition
  input wire logic                       clk,
  input wire logic                       rst_n,
  input wire logic                       ce,
  input wire logic                       acq_busy,
  // Register port
  input wire logic [7:0]                 reg_addr,
  input wire logic [31:0]                reg_wdata,
  input wire logic                       reg_wr,
  input wire logic                       reg_rd,
  input wire logic [31:0]                reg_rdata,
  // Live configuration
  input wire logic [PARAM_N*PARAM_W-1:0] live_params,
  input wire logic [LUT_N*PARAM_W-1:0]   lut_table,
  input wire logic                       cfg_busy
);
  logic [1:0]         slot_ff;
  logic [4:0]         busy_cnt_ff;
  logic [IDX_W-1:0]   idx_ff;
  logic [PARAM_W-1:0] val_ff;
  logic [PARAM_W-1:0] word_ff;
  logic               cmd_st;
  logic               live_wr;

  // Mirror of the slot choice, since a store to slot 0 is refused
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) slot_ff <= SLOT_CHOICE_RST;
    else if (ce && reg_wr && reg_addr == ADDR_SLOT_CHOICE)
      slot_ff <= reg_wdata[1:0];
  end

  // Busy run length; saturates so a stuck flag cannot wrap under the bound
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) busy_cnt_ff <= 5'h00;
    else if (!cfg_busy) busy_cnt_ff <= 5'h00;
    else if (busy_cnt_ff != 5'h1F) busy_cnt_ff <= busy_cnt_ff + 5'h01;
  end

  // Request fields and addressed live word, one cycle later
  always_ff @(posedge clk) begin
    idx_ff  <= reg_addr[4:2];
    val_ff  <= reg_wdata[15:0];
    word_ff <= live_params[reg_addr[4:2]*PARAM_W +: PARAM_W];
  end

  assign cmd_st  = ce && reg_wr && reg_addr == ADDR_STORE_CMD && reg_wdata[0];
  assign live_wr = ce && reg_wr && reg_addr < ADDR_FACTORY_CHOICE
                   && reg_addr[1:0] == 2'h0 && !cfg_busy;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_copy;
    cfg_busy [*8] ##1 !cfg_busy;
  endsequence

  AST_BOOT_COPY: assert property ($rose(rst_n) |-> s_copy)
    else $error("boot copy not eight cycles");
  AST_STORE_COPY: assert property (
    cmd_st && !cfg_busy && slot_ff != 2'h0 |=> s_copy)
    else $error("store copy not eight cycles");
  AST_STORE_NO_SLOT: assert property (
    cmd_st && slot_ff == 2'h0 |=> !cfg_busy)
    else $error("store to slot 0 started a copy");
  AST_RESTORE_ACQ: assert property (
    ce && reg_wr && reg_addr == ADDR_RESTORE_CMD && reg_wdata[0] && acq_busy
    |=> (!cfg_busy && $stable(live_params)) [*2])
    else $error("restore during acquisition acted");
  AST_LIVE_WRITE: assert property (
    live_wr |=> live_params[idx_ff*PARAM_W +: PARAM_W] == val_ff)
    else $error("live word write lost");
  AST_LIVE_READ: assert property (
    ce && reg_rd && reg_addr < ADDR_FACTORY_CHOICE
    |=> reg_rdata[15:0] == word_ff)
    else $error("live word read wrong");
  AST_RDATA_IDLE: assert property (
    ce && !reg_rd |=> reg_rdata == 32'h00000000)
    else $error("read data outside its cycle");
  AST_STATUS_BITS: assert property (
    ce && reg_rd && reg_addr == ADDR_STATUS
    |=> reg_rdata[ST_ACQ] == $past(acq_busy)
        && reg_rdata[ST_BUSY] == $past(cfg_busy))
    else $error("status bits wrong");
  AST_BUSY_BOUND: assert property (busy_cnt_ff <= 5'h08)
    else $error("copy busy too long");
  AST_LUT_KEPT: assert property (
    ce && reg_wr && reg_addr == ADDR_RESTORE_CMD && reg_wdata[0]
    |=> $stable(lut_table) [*8])
    else $error("restore touched the table");
endmodule

bind ccs_config_sets ccs_config_sets_properties u_props (
  .clk(clk), .rst_n(rst_n), .ce(ce), .acq_busy(acq_busy),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .live_params(live_params),
  .lut_table(lut_table), .cfg_busy(cfg_busy));

// *** verification/ccs_config_sets_bench.sv ***
/*
  Self-checking bench for the configuration set manager: boot, live
  writes, store and restore of all slots, factory images, refusals.
  Assumes the store is initialised once at start by nv_rst_n.
*/
`timescale 1ns/1ns
module ccs_config_sets_bench
  import ccs_pkg::*;
;
  logic                       clk, rst_n, ce, nv_rst_n, acq_busy;
  logic [7:0]                 reg_addr;
  logic [31:0]                reg_wdata, reg_rdata, rdv;
  logic                       reg_wr, reg_rd, cfg_busy;
  logic [PARAM_N*PARAM_W-1:0] live_params;
  logic [LUT_N*PARAM_W-1:0]   lut_table, lut_m;
  logic [15:0]                exp_live [PARAM_N];
  logic [15:0]                saved [4][PARAM_N];
  int                         error_cnt, comparisons, cycles, seed, s;

  ccs_config_sets uut (
    .clk(clk), .rst_n(rst_n), .ce(ce), .nv_rst_n(nv_rst_n),
    .acq_busy(acq_busy), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .live_params(live_params), .lut_table(lut_table),
    .cfg_busy(cfg_busy));

  // 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic report_and_stop();
    $display("Comparisons %0d, errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Whole run is a few hundred cycles; this catches a hung copy
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt = error_cnt + 1;
      report_and_stop();
    end
  end

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // Let the launching edge land before looking at busy
  task automatic idle();
    int n;
    n = 0;
    repeat (2) @(posedge clk);
    while (cfg_busy !== 1'b0 && n < 40) begin
      @(posedge clk);
      n++;
    end
    check("cfg_busy", {31'h0, cfg_busy}, 32'h0);
  endtask

  task automatic chk_live();
    for (int i = 0; i < PARAM_N; i++)
      check("live", {16'h0, live_params[i*PARAM_W +: PARAM_W]},
            {16'h0, exp_live[i]});
  endtask

  // Expected factory word; images differ from standard in a few words
  function automatic logic [15:0] fac_w(input int img, input int i);
    fac_w = (i == 1) ? EXPOSURE_DEF : (i >= 6) ? WB_UNITY : GAIN_LOW;
    if (img == 1 && i == 0) fac_w = GAIN_6DB;
    if (img == 2 && (i == 2 || i == 3)) fac_w = AUTO_CONT;
    if (img == 2 && i == 4) fac_w = POL_MIN_GAIN;
    if (img == 3 && i == 6) fac_w = WB_DAY_RED;
    if (img == 3 && i == 7) fac_w = WB_DAY_BLUE;
  endfunction

  task automatic exp_fac(input int img);
    for (int i = 0; i < PARAM_N; i++) exp_live[i] = fac_w(img, i);
  endtask

  task automatic reboot();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    idle();
  endtask

  initial begin
    {ce, nv_rst_n, rst_n, acq_busy} = 4'h8;
    {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
    {error_cnt, comparisons, cycles} = '0;
    seed = 69;
    repeat (10) @(posedge clk);
    nv_rst_n <= 1'b1;
    rst_n    <= 1'b1;
    idle();
    exp_fac(2);
    chk_live();
    check("lut", {31'h0, |lut_table}, 32'h0);
    // Random live words, written and read back
    for (int i = 0; i < PARAM_N; i++) begin
      exp_live[i] = 16'($random(seed));
      wr(ADDR_LIVE_BASE + 8'(4*i), {16'h0, exp_live[i]});
    end
    chk_live();
    for (int i = 0; i < PARAM_N; i++) begin
      rd(ADDR_LIVE_BASE + 8'(4*i), rdv);
      check("live_rd", {16'h0, rdv[15:0]}, {16'h0, exp_live[i]});
    end
    wr(8'h38, 32'hFFFFFFFF);
    rd(8'h38, rdv);
    check("unmapped", rdv, 32'h0);
    wr(ADDR_RESTORE_CMD, 32'h1);
    rd(ADDR_STATUS, rdv);
    check("unsaved", {30'h0, rdv[1:0]}, 32'h2);
    wr(ADDR_STATUS, 32'h2);
    rd(ADDR_STATUS, rdv);
    check("clr", {31'h0, rdv[ST_REFUSED]}, 32'h0);
    // Store all slots, then slot 1 again to show full overwrite
    for (int k = 0; k < 4; k++) begin
      s = (k % 3) + 1;
      for (int i = 0; i < PARAM_N; i++) begin
        saved[s][i] = 16'($random(seed));
        wr(ADDR_LIVE_BASE + 8'(4*i), {16'h0, saved[s][i]});
      end
      wr(ADDR_SLOT_CHOICE, 32'(s));
      wr(ADDR_STORE_CMD, 32'h1);
      idle();
    end
    rd(ADDR_STATUS, rdv);
    check("valid", {29'h0, rdv[6:4]}, 32'h7);
    for (int i = 0; i < LUT_N; i++)
      wr(ADDR_LUT_BASE + 8'(4*i), 32'($random(seed)));
    lut_m = lut_table;
    for (s = 3; s >= 1; s--) begin
      wr(ADDR_SLOT_CHOICE, 32'(s));
      wr(ADDR_RESTORE_CMD, 32'h1);
      idle();
      exp_live = saved[s];
      chk_live();
    end
    check("lut_kept", {31'h0, lut_table != lut_m}, 32'h0);
    // Every factory image through the default set
    for (int img = 0; img < 4; img++) begin
      wr(ADDR_FACTORY_CHOICE, 32'(img));
      wr(ADDR_SLOT_CHOICE, 32'h0);
      wr(ADDR_RESTORE_CMD, 32'h1);
      idle();
      exp_fac(img);
      chk_live();
    end
    // Requests during acquisition are refused and flagged
    @(posedge clk);
    acq_busy <= 1'b1;
    wr(ADDR_FACTORY_CHOICE, 32'h0);
    wr(ADDR_SLOT_CHOICE, 32'h1);
    wr(ADDR_RESTORE_CMD, 32'h1);
    rd(ADDR_FACTORY_CHOICE, rdv);
    check("fc_kept", rdv, 32'h3);
    chk_live();
    rd(ADDR_STATUS, rdv);
    check("refused", {30'h0, rdv[2:1]}, 32'h3);
    @(posedge clk);
    acq_busy <= 1'b0;
    wr(ADDR_STATUS, 32'h2);
    wr(ADDR_SLOT_CHOICE, 32'h0);
    wr(ADDR_STORE_CMD, 32'h1);
    rd(ADDR_STATUS, rdv);
    check("st_slot0", {31'h0, rdv[ST_REFUSED]}, 32'h1);
    // Boot from slot 3, then from the default set, across resets
    wr(ADDR_BOOT_CHOICE, 32'h3);
    reboot();
    exp_live = saved[3];
    chk_live();
    check("lut_rst", {31'h0, |lut_table}, 32'h0);
    wr(ADDR_BOOT_CHOICE, 32'h0);
    reboot();
    exp_fac(3);
    chk_live();
    report_and_stop();
  end
endmodule
